// ===== rtl/demand_pkg.sv
// Constants and types for the redundant demand front end
// Contract
// - Compare primary and backup demands only while tracking supervision enabled; off at reset.
// - Hold a maximum deviation setting, 0 to 100 percent, default 10.
// - Raise tracking fault only when deviation exceeds maximum longer than delay.
// - Tracking delay settable 0 to 10 seconds, default 1 second.
// - Switch mode: on tracking fault use backup, flag primary failed.
// - Default mode: on tracking fault keep primary, flag backup failed.
// - Low-pass filter the demand only when enabled; bypass by default.
// - Filter cut-off settable 1 to 20 Hz, default 20.
// - Lower duty breakpoint 5 to 95 percent, default 10, maps to lower demand.
// - Lower breakpoint above upper breakpoint gives reverse-acting demand.
// - Upper duty breakpoint 5 to 95 percent, default 90, maps to upper demand.
// - Signed duty offset -20 to +20 percent, default 0, added before scaling.
// - Demand at lower breakpoint 0 to 100 percent, default 0.
// - Demand at upper breakpoint 0 to 100 percent, default 100.
// - Duty low fault with threshold 2 to 50 percent, default 2.
// - Duty high fault with threshold 50 to 98 percent, default 98.
// - Backup returns control to primary once difference within failback inhibit, default 5.
// - Primary and backup sources selectable among PWM, analog, CAN; PWM default.
package demand_pkg;
    localparam logic [7:0]  A_CTRL    = 8'h00;
    localparam logic [7:0]  A_TRACK   = 8'h04;
    localparam logic [7:0]  A_DELAY   = 8'h08;
    localparam logic [7:0]  A_FILT    = 8'h0C;
    localparam logic [7:0]  A_SCALEX  = 8'h10;
    localparam logic [7:0]  A_SCALEY  = 8'h14;
    localparam logic [7:0]  A_FTH     = 8'h18;
    localparam logic [7:0]  A_STAT    = 8'h1C;
    localparam logic [7:0]  A_DEM     = 8'h20;
    localparam int          NCFG      = 7;
    // Reset words: CTRL all off/PWM, dev 10 inh 5, 1000 ms, 20 Hz
    localparam logic [31:0] RST_CTRL  = 32'h0000_0000;
    localparam logic [31:0] RST_TRACK = 32'h0000_050A;
    localparam logic [31:0] RST_DELAY = 32'h0000_03E8;
    localparam logic [31:0] RST_FILT  = 32'h0000_0014;
    localparam logic [31:0] RST_SCX   = 32'h0000_5A0A;
    localparam logic [31:0] RST_SCY   = 32'h0000_6400;
    localparam logic [31:0] RST_FTH   = 32'h0000_6202;
    localparam logic [7:0]  PCT_MAX   = 8'h64;
    localparam logic [13:0] DELAY_MAX = 14'h2710;
    localparam logic [4:0]  FC_MIN    = 5'h01;
    localparam logic [4:0]  FC_MAX    = 5'h14;
    localparam int          CLK_MHZ   = 250;
    localparam int          TICK_US   = 1000;
    localparam int          TICK_CYC  = CLK_MHZ * TICK_US;
    // Q16 gain per Hz at 1 kHz update: 2*pi/1000*65536
    localparam logic [8:0]  FILT_K    = 9'h19B;
    localparam logic [1:0]  SRC_PWM   = 2'h0;
    localparam logic [1:0]  SRC_ANA   = 2'h1;
    localparam logic [1:0]  SRC_CAN   = 2'h2;
    localparam logic [1:0]  RESP_OK   = 2'h0;
    localparam logic [1:0]  RESP_ERR  = 2'h2;

    typedef enum logic [2:0] {
        TRK_OK    = 3'b001,
        TRK_TIME  = 3'b010,
        TRK_FAULT = 3'b100
    } trk_state_t;

    typedef struct packed {
        logic              track_en;
        logic              sw_bkp;
        logic              filt_en;
        logic [1:0]        pri_src;
        logic [1:0]        bak_src;
        logic [7:0]        dev_max;
        logic [7:0]        fb_inh;
        logic [13:0]       delay_ms;
        logic [4:0]        cutoff;
        logic [7:0]        x_lo;
        logic [7:0]        x_hi;
        logic signed [7:0] offs;
        logic [7:0]        y_lo;
        logic [7:0]        y_hi;
        logic [7:0]        th_lo;
        logic [7:0]        th_hi;
    } cfg_t;
endpackage : demand_pkg

// ===== rtl/demand_front_end.sv
// Redundant position demand selection, PWM scaling and filter
//
// The register offsets and the AXI4-Lite interface to the registers are this design's own decisions.
`timescale 1ns/1ns
module demand_front_end #(
    parameter int TICK_CYCLES = demand_pkg::TICK_CYC
) (
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic [7:0]  awaddr,
    input  wire logic        awvalid,
    output logic             awready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    input  wire logic        wvalid,
    output logic             wready,
    output logic [1:0]       bresp,
    output logic             bvalid,
    input  wire logic        bready,
    input  wire logic [7:0]  araddr,
    input  wire logic        arvalid,
    output logic             arready,
    output logic [31:0]      rdata,
    output logic [1:0]       rresp,
    output logic             rvalid,
    input  wire logic        rready,
    input  wire logic [7:0]  pwm_duty,
    input  wire logic [7:0]  analog_demand,
    input  wire logic [7:0]  can_demand,
    output logic [7:0]       demand_out,
    output logic             track_fault,
    output logic             primary_failed,
    output logic             backup_failed,
    output logic             backup_in_control,
    output logic             duty_low_fault,
    output logic             duty_high_fault
);
    initial begin
        if (TICK_CYCLES < 2) $error("TICK_CYCLES too small");
    end

    function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
                                          input logic [3:0] s);
        for (int i = 0; i < 4; i++) begin
            if (s[i]) o[i*8 +: 8] = n[i*8 +: 8];
        end
        return o;
    endfunction : merge

    function automatic logic [7:0] clamp_pct(input logic signed [20:0] v);
        if (v < 0) return 8'h00;
        if (v > $signed({13'h0, demand_pkg::PCT_MAX})) return demand_pkg::PCT_MAX;
        return v[7:0];
    endfunction : clamp_pct

    function automatic logic [7:0] pick(input logic [1:0] s, input logic [7:0] p,
                                        input logic [7:0] a, input logic [7:0] c);
        if (s == demand_pkg::SRC_ANA) return a;
        if (s == demand_pkg::SRC_CAN) return c;
        return p;
    endfunction : pick

    // Register file and AXI4-Lite slave
    logic [31:0] cfg_ff [demand_pkg::NCFG];
    logic [31:0] nxt_cfg [demand_pkg::NCFG];
    logic [7:0]  aw_ff, nxt_aw;
    logic [31:0] wd_ff, nxt_wd, rdata_ff, nxt_rdata;
    logic [3:0]  ws_ff, nxt_ws;
    logic        awr_ff, nxt_awr, wr_ff, nxt_wr, awh_ff, nxt_awh, wh_ff, nxt_wh;
    logic        bv_ff, nxt_bv, arr_ff, nxt_arr, rv_ff, nxt_rv;
    logic [1:0]  br_ff, nxt_br, rr_ff, nxt_rr;
    logic [31:0] stat_w;
    logic [7:0]  dem_ff;
    demand_pkg::cfg_t cfg;

    assign cfg.track_en = cfg_ff[0][0];
    assign cfg.sw_bkp   = cfg_ff[0][1];
    assign cfg.filt_en  = cfg_ff[0][2];
    assign cfg.pri_src  = cfg_ff[0][5:4];
    assign cfg.bak_src  = cfg_ff[0][7:6];
    assign cfg.dev_max  = cfg_ff[1][7:0];
    assign cfg.fb_inh   = cfg_ff[1][15:8];
    assign cfg.delay_ms = (cfg_ff[2][13:0] > demand_pkg::DELAY_MAX) ?
                          demand_pkg::DELAY_MAX : cfg_ff[2][13:0];
    assign cfg.cutoff   = (cfg_ff[3][4:0] < demand_pkg::FC_MIN) ? demand_pkg::FC_MIN :
                          (cfg_ff[3][4:0] > demand_pkg::FC_MAX) ? demand_pkg::FC_MAX :
                          cfg_ff[3][4:0];
    assign cfg.x_lo     = cfg_ff[4][7:0];
    assign cfg.x_hi     = cfg_ff[4][15:8];
    assign cfg.offs     = cfg_ff[4][23:16];
    assign cfg.y_lo     = cfg_ff[5][7:0];
    assign cfg.y_hi     = cfg_ff[5][15:8];
    assign cfg.th_lo    = cfg_ff[6][7:0];
    assign cfg.th_hi    = cfg_ff[6][15:8];

    always_comb begin
        nxt_cfg = cfg_ff;
        nxt_aw = aw_ff;
        nxt_wd = wd_ff;
        nxt_ws = ws_ff;
        nxt_awh = awh_ff;
        nxt_wh = wh_ff;
        nxt_bv = bv_ff;
        nxt_br = br_ff;
        if (awvalid && awr_ff) begin
            nxt_aw = awaddr;
            nxt_awh = 1'b1;
        end
        if (wvalid && wr_ff) begin
            nxt_wd = wdata;
            nxt_ws = wstrb;
            nxt_wh = 1'b1;
        end
        if (bv_ff && bready) nxt_bv = 1'b0;
        if (awh_ff && wh_ff && !bv_ff) begin
            nxt_awh = 1'b0;
            nxt_wh = 1'b0;
            nxt_bv = 1'b1;
            nxt_br = demand_pkg::RESP_OK;
            if (aw_ff[1:0] == 2'h0 && aw_ff[7:2] < 6'(demand_pkg::NCFG)) begin
                nxt_cfg[aw_ff[4:2]] = merge(cfg_ff[aw_ff[4:2]], wd_ff, ws_ff);
            end else if (aw_ff != demand_pkg::A_STAT && aw_ff != demand_pkg::A_DEM) begin
                nxt_br = demand_pkg::RESP_ERR;
            end
        end
        nxt_awr = !nxt_awh;
        nxt_wr = !nxt_wh;
    end

    assign stat_w = {25'h0, backup_in_control, primary_failed, backup_failed,
                     track_fault, duty_high_fault, duty_low_fault, 1'b0};

    always_comb begin
        nxt_arr = arr_ff;
        nxt_rv = rv_ff;
        nxt_rr = rr_ff;
        nxt_rdata = rdata_ff;
        if (rv_ff && rready) begin
            nxt_rv = 1'b0;
            nxt_arr = 1'b1;
        end
        if (arvalid && arr_ff) begin
            nxt_arr = 1'b0;
            nxt_rv = 1'b1;
            nxt_rr = demand_pkg::RESP_OK;
            nxt_rdata = 32'h0000_0000;
            if (araddr[1:0] == 2'h0 && araddr[7:2] < 6'(demand_pkg::NCFG)) begin
                nxt_rdata = cfg_ff[araddr[4:2]];
            end else if (araddr == demand_pkg::A_STAT) begin
                nxt_rdata = stat_w;
            end else if (araddr == demand_pkg::A_DEM) begin
                nxt_rdata = {24'h0, dem_ff};
            end else begin
                nxt_rr = demand_pkg::RESP_ERR;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cfg_ff <= '{demand_pkg::RST_CTRL, demand_pkg::RST_TRACK, demand_pkg::RST_DELAY,
                        demand_pkg::RST_FILT, demand_pkg::RST_SCX, demand_pkg::RST_SCY,
                        demand_pkg::RST_FTH};
            aw_ff <= 8'h00;
            wd_ff <= 32'h0000_0000;
            ws_ff <= 4'h0;
            awh_ff <= 1'b0;
            wh_ff <= 1'b0;
            awr_ff <= 1'b0;
            wr_ff <= 1'b0;
            bv_ff <= 1'b0;
            br_ff <= 2'h0;
            arr_ff <= 1'b0;
            rv_ff <= 1'b0;
            rr_ff <= 2'h0;
            rdata_ff <= 32'h0000_0000;
        end else begin
            cfg_ff <= nxt_cfg;
            aw_ff <= nxt_aw;
            wd_ff <= nxt_wd;
            ws_ff <= nxt_ws;
            awh_ff <= nxt_awh;
            wh_ff <= nxt_wh;
            awr_ff <= nxt_awr;
            wr_ff <= nxt_wr;
            bv_ff <= nxt_bv;
            br_ff <= nxt_br;
            arr_ff <= nxt_arr | (!arr_ff && !rv_ff);
            rv_ff <= nxt_rv;
            rr_ff <= nxt_rr;
            rdata_ff <= nxt_rdata;
        end
    end

    assign awready = awr_ff;
    assign wready = wr_ff;
    assign bvalid = bv_ff;
    assign bresp = br_ff;
    assign arready = arr_ff;
    assign rvalid = rv_ff;
    assign rresp = rr_ff;
    assign rdata = rdata_ff;

    // PWM offset, two-point scaling and duty faults
    logic signed [9:0]  d_adj, dx, dy, den;
    logic signed [20:0] num, q;
    logic [7:0]         d_c, pwm_dem, pri_d, bak_d, dev;

    always_comb begin
        d_adj = $signed({2'b00, pwm_duty}) + 10'(cfg.offs);
        d_c = clamp_pct(21'(d_adj));
        dx = $signed({2'b00, d_c}) - $signed({2'b00, cfg.x_lo});
        dy = $signed({2'b00, cfg.y_hi}) - $signed({2'b00, cfg.y_lo});
        den = $signed({2'b00, cfg.x_hi}) - $signed({2'b00, cfg.x_lo});
        num = 21'(dx * dy);
        q = (den == 10'sh000) ? 21'sh00000 : num / 21'(den);
        pwm_dem = clamp_pct(q + $signed({13'h0, cfg.y_lo}));
        pri_d = pick(cfg.pri_src, pwm_dem, analog_demand, can_demand);
        bak_d = pick(cfg.bak_src, pwm_dem, analog_demand, can_demand);
        dev = (pri_d > bak_d) ? pri_d - bak_d : bak_d - pri_d;
    end

    // Millisecond tick for delay and filter update
    logic [31:0] tick_cnt_ff, nxt_tick_cnt;
    logic        tick;
    assign tick = (tick_cnt_ff == 32'(TICK_CYCLES - 1));
    always_comb nxt_tick_cnt = tick ? 32'h0000_0000 : tick_cnt_ff + 32'h0000_0001;

    // Tracking supervision
    demand_pkg::trk_state_t st_ff, nxt_st;
    logic [13:0] ms_ff, nxt_ms;
    logic        exceed, restored;
    assign exceed = cfg.track_en && (dev > cfg.dev_max);
    assign restored = (dev <= cfg.fb_inh);

    always_comb begin
        nxt_st = st_ff;
        nxt_ms = ms_ff;
        case (st_ff)
            demand_pkg::TRK_OK: begin
                nxt_ms = 14'h0000;
                if (exceed) nxt_st = demand_pkg::TRK_TIME;
            end
            demand_pkg::TRK_TIME: begin
                if (!exceed) begin
                    nxt_st = demand_pkg::TRK_OK;
                end else if (tick) begin
                    if (ms_ff >= cfg.delay_ms) nxt_st = demand_pkg::TRK_FAULT;
                    nxt_ms = ms_ff + 14'h0001;
                end
            end
            demand_pkg::TRK_FAULT: begin
                if (!cfg.track_en || restored) nxt_st = demand_pkg::TRK_OK;
            end
            default: nxt_st = demand_pkg::TRK_OK;
        endcase
    end

    // Demand selection and optional low-pass filter
    logic [7:0]         sel_d;
    logic [23:0]        acc_ff, nxt_acc;
    logic signed [24:0] err;
    logic signed [40:0] step;
    logic               use_bkp;
    assign use_bkp = (nxt_st == demand_pkg::TRK_FAULT) && cfg.sw_bkp;
    assign sel_d = use_bkp ? bak_d : pri_d;

    always_comb begin
        err = $signed({1'b0, sel_d, 16'h0000}) - $signed({1'b0, acc_ff});
        step = 41'(err * $signed({2'b00, 14'(cfg.cutoff * demand_pkg::FILT_K)}));
        nxt_acc = acc_ff;
        if (!cfg.filt_en) begin
            nxt_acc = {sel_d, 16'h0000};
        end else if (tick) begin
            nxt_acc = acc_ff + 24'(step >>> 16);
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tick_cnt_ff <= 32'h0000_0000;
            st_ff <= demand_pkg::TRK_OK;
            ms_ff <= 14'h0000;
            acc_ff <= 24'h00_0000;
            dem_ff <= 8'h00;
            track_fault <= 1'b0;
            primary_failed <= 1'b0;
            backup_failed <= 1'b0;
            backup_in_control <= 1'b0;
            duty_low_fault <= 1'b0;
            duty_high_fault <= 1'b0;
        end else begin
            tick_cnt_ff <= nxt_tick_cnt;
            st_ff <= nxt_st;
            ms_ff <= nxt_ms;
            acc_ff <= nxt_acc;
            dem_ff <= cfg.filt_en ? nxt_acc[23:16] : sel_d;
            track_fault <= (nxt_st == demand_pkg::TRK_FAULT);
            primary_failed <= use_bkp;
            backup_failed <= (nxt_st == demand_pkg::TRK_FAULT) && !cfg.sw_bkp;
            backup_in_control <= use_bkp;
            duty_low_fault <= (pwm_duty < cfg.th_lo);
            duty_high_fault <= (pwm_duty > cfg.th_hi);
        end
    end
    assign demand_out = dem_ff;

    // Checks
    sequence s_exceed_idle;
        st_ff == demand_pkg::TRK_OK && exceed;
    endsequence

    a_sup_off: assert property (@(posedge aclk) disable iff (!aresetn)
        !cfg.track_en |=> !track_fault) else $error("fault while supervision off");
    a_no_early: assert property (@(posedge aclk) disable iff (!aresetn)
        s_exceed_idle |=> !track_fault) else $error("fault without delay");
    a_fault_cause: assert property (@(posedge aclk) disable iff (!aresetn)
        $rose(track_fault) |-> $past(st_ff == demand_pkg::TRK_TIME && tick))
        else $error("fault without timed deviation");
    a_switch_bkp: assert property (@(posedge aclk) disable iff (!aresetn)
        track_fault && $past(cfg.sw_bkp) |-> primary_failed && backup_in_control)
        else $error("backup not in control");
    a_keep_pri: assert property (@(posedge aclk) disable iff (!aresetn)
        track_fault && !$past(cfg.sw_bkp) |-> backup_failed && !backup_in_control)
        else $error("primary not kept");
    a_failback: assert property (@(posedge aclk) disable iff (!aresetn)
        $fell(backup_in_control) && $past(cfg.track_en) && $past(cfg.sw_bkp)
        |-> $past(restored)) else $error("early failback");
    a_duty_low: assert property (@(posedge aclk) disable iff (!aresetn)
        (pwm_duty < cfg.th_lo) |=> duty_low_fault) else $error("duty low missed");
    a_duty_high: assert property (@(posedge aclk) disable iff (!aresetn)
        (pwm_duty > cfg.th_hi) |=> duty_high_fault) else $error("duty high missed");
    a_dem_clamp: assert property (@(posedge aclk) disable iff (!aresetn)
        dem_ff <= demand_pkg::PCT_MAX) else $error("demand out of range");
    a_bypass: assert property (@(posedge aclk) disable iff (!aresetn)
        !cfg.filt_en |=> dem_ff == $past(sel_d)) else $error("filter not bypassed");
endmodule : demand_front_end

// ===== bench/ecu_model.sv
// Engine controller model driving the demand inputs
`timescale 1ns/1ns
module ecu_model (
    input  wire logic       aclk,
    input  wire logic       aresetn,
    input  wire logic       slow,
    input  wire logic [7:0] duty_set,
    input  wire logic [7:0] ana_set,
    input  wire logic [7:0] can_set,
    output logic      [7:0] pwm_duty,
    output logic      [7:0] analog_demand,
    output logic      [7:0] can_demand
);
    // Slow mode slews one percent per cycle toward the target
    function automatic logic [7:0] slew(input logic [7:0] cur, input logic [7:0] tgt);
        if (cur < tgt) begin
            return cur + 8'h01;
        end
        if (cur > tgt) begin
            return cur - 8'h01;
        end
        return cur;
    endfunction : slew

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pwm_duty      <= 8'h00;
            analog_demand <= 8'h00;
            can_demand    <= 8'h00;
        end else if (slow) begin
            pwm_duty      <= slew(pwm_duty, duty_set);
            analog_demand <= slew(analog_demand, ana_set);
            can_demand    <= slew(can_demand, can_set);
        end else begin
            pwm_duty      <= duty_set;
            analog_demand <= ana_set;
            can_demand    <= can_set;
        end
    end
endmodule : ecu_model

// ===== bench/tb_demand_front_end.sv
// Self-checking bench for the redundant demand front end
`timescale 1ns/1ns
module tb_demand_front_end;
    localparam int TK = 10;
    logic        aclk, aresetn, slow, awvalid, wvalid, bready, arvalid, rready;
    logic        awready, wready, bvalid, arready, rvalid, track_fault;
    logic        primary_failed, backup_failed, backup_in_control;
    logic        duty_low_fault, duty_high_fault;
    logic [7:0]  awaddr, araddr, duty_set, ana_set, can_set, demand_out;
    logic [7:0]  pwm_duty, analog_demand, can_demand;
    logic [31:0] wdata, rdata;
    logic [3:0]  wstrb;
    logic [1:0]  bresp, rresp;
    logic [7:0]  dv [3];
    int          errors, n_compared, i, n;
    logic [7:0]  du [10] = '{8'h01, 8'h02, 8'h05, 8'h0A, 8'h1E, 8'h32, 8'h5A, 8'h5F, 8'h62, 8'h63};
    logic [7:0]  dm [10] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h19, 8'h32, 8'h64, 8'h64, 8'h64, 8'h64};
    logic [31:0] sc [4][4] = '{'{32'h000A_5A0A, 32'h0000_6400, 32'h28, 32'h32},
        '{32'h00EC_5A0A, 32'h0000_6400, 32'h46, 32'h32},
        '{32'h0000_0A5A, 32'h0000_6400, 32'h1E, 32'h4B},
        '{32'h0000_5A0A, 32'h0000_3C14, 32'h32, 32'h28}};
    logic [31:0] rst [7] = '{demand_pkg::RST_CTRL, demand_pkg::RST_TRACK, demand_pkg::RST_DELAY,
        demand_pkg::RST_FILT, demand_pkg::RST_SCX, demand_pkg::RST_SCY, demand_pkg::RST_FTH};

    demand_front_end #(.TICK_CYCLES(TK)) i_demand_front_end (
        .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
        .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
        .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .pwm_duty(pwm_duty), .analog_demand(analog_demand), .can_demand(can_demand),
        .demand_out(demand_out), .track_fault(track_fault), .primary_failed(primary_failed),
        .backup_failed(backup_failed), .backup_in_control(backup_in_control),
        .duty_low_fault(duty_low_fault), .duty_high_fault(duty_high_fault));

    ecu_model i_ecu_model (
        .aclk(aclk), .aresetn(aresetn), .slow(slow), .duty_set(duty_set), .ana_set(ana_set),
        .can_set(can_set), .pwm_duty(pwm_duty), .analog_demand(analog_demand),
        .can_demand(can_demand));

    initial begin
        aclk = 1'b0;
        forever #2 aclk = ~aclk;
    end

    task automatic end_of_test;
        $display("compared %0d mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : end_of_test

    task automatic chk(input string s, input logic [31:0] g, input logic [31:0] e);
        n_compared++;
        if (g !== e) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", s, e, g);
        end
    endtask : chk

    task automatic tmo(input int k, input int lim);
        if (k >= lim) begin
            errors++;
            $display("[ERR] wait expected done seen timeout");
            end_of_test();
        end
    endtask : tmo

    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
        int   k;
        logic aw_p, w_p;
        aw_p = 1'b1;
        w_p  = 1'b1;
        awaddr  <= a;
        wdata   <= d;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        for (k = 0; k < 50 && (aw_p || w_p); k++) begin
            @(posedge aclk);
            if (aw_p && awready) begin
                awvalid <= 1'b0;
                aw_p = 1'b0;
            end
            if (w_p && wready) begin
                wvalid <= 1'b0;
                w_p = 1'b0;
            end
        end
        tmo(k, 50);
        for (k = 0; k < 50 && bvalid !== 1'b1; k++) @(posedge aclk);
        tmo(k, 50);
        chk("bresp", bresp, e);
        bready <= 1'b0;
        @(posedge aclk);
    endtask : wr

    task automatic rdc(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
        int k;
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        for (k = 0; k < 50 && !(arvalid && arready); k++) @(posedge aclk);
        tmo(k, 50);
        arvalid <= 1'b0;
        for (k = 0; k < 50 && rvalid !== 1'b1; k++) @(posedge aclk);
        tmo(k, 50);
        chk("rdata", rdata, e);
        chk("rresp", rresp, er);
        rready <= 1'b0;
        @(posedge aclk);
    endtask : rdc

    task automatic drv(input logic [7:0] d, input logic [7:0] a, input logic [7:0] c);
        duty_set <= d;
        ana_set  <= a;
        can_set  <= c;
        repeat (4) @(posedge aclk);
    endtask : drv

    task automatic wait_flag(input int lim);
        for (n = 0; n < lim && track_fault !== 1'b1; n++) @(posedge aclk);
        tmo(n, lim);
    endtask : wait_flag

    initial begin
        {aresetn, slow, awvalid, wvalid, bready, arvalid, rready} = '0;
        {awaddr, araddr, wdata} = '0;
        wstrb = 4'hF;
        {duty_set, ana_set, can_set} = '0;
        errors = 0;
        n_compared = 0;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        for (i = 0; i < 7; i++) begin
            rdc(8'(4 * i), rst[i], 2'h0);
        end
        rdc(8'h24, 32'h0, demand_pkg::RESP_ERR);
        wr(8'h24, 32'h1, demand_pkg::RESP_ERR);
        wstrb <= 4'h1;
        wr(demand_pkg::A_TRACK, 32'h0000_FF0C, 2'h0);
        wstrb <= 4'hF;
        rdc(demand_pkg::A_TRACK, 32'h0000_050C, 2'h0);
        wr(demand_pkg::A_DELAY, 32'h0000_3FFF, 2'h0);
        rdc(demand_pkg::A_DELAY, 32'h0000_3FFF, 2'h0);
        wr(demand_pkg::A_FILT, 32'h0000_0019, 2'h0);
        rdc(demand_pkg::A_FILT, 32'h0000_0019, 2'h0);
        $display("test registers done");
        for (i = 0; i < 10; i++) begin
            drv(du[i], 8'h00, 8'h00);
            chk("demand", demand_out, dm[i]);
            chk("low fault", duty_low_fault, du[i] < 8'h02);
            chk("high fault", duty_high_fault, du[i] > 8'h62);
        end
        rdc(demand_pkg::A_STAT, 32'h0000_0004, 2'h0);
        rdc(demand_pkg::A_DEM, 32'h0000_0064, 2'h0);
        wr(demand_pkg::A_FTH, 32'h0000_3C32, 2'h0);
        drv(8'h28, 8'h00, 8'h00);
        chk("low fault", duty_low_fault, 1'b1);
        drv(8'h46, 8'h00, 8'h00);
        chk("high fault", duty_high_fault, 1'b1);
        wr(demand_pkg::A_FTH, demand_pkg::RST_FTH, 2'h0);
        for (i = 0; i < 4; i++) begin
            wr(demand_pkg::A_SCALEX, sc[i][0], 2'h0);
            wr(demand_pkg::A_SCALEY, sc[i][1], 2'h0);
            drv(sc[i][2][7:0], 8'h00, 8'h00);
            chk("scaled demand", demand_out, sc[i][3]);
        end
        drv(8'h1E, 8'h21, 8'h4D);
        for (i = 0; i < 3; i++) begin
            wr(demand_pkg::A_CTRL, 32'(i << 4), 2'h0);
            repeat (3) @(posedge aclk);
            chk("source demand", demand_out, i == 0 ? 8'h1E : (i == 1 ? 8'h21 : 8'h4D));
        end
        $display("test scaling done");
        wr(demand_pkg::A_SCALEX, demand_pkg::RST_SCX, 2'h0);
        wr(demand_pkg::A_SCALEY, demand_pkg::RST_SCY, 2'h0);
        wr(demand_pkg::A_DELAY, 32'h3, 2'h0);
        wr(demand_pkg::A_CTRL, 32'h40, 2'h0);
        drv(8'h32, 8'h41, 8'h00);
        repeat (10 * TK) @(posedge aclk);
        chk("fault while off", track_fault, 1'b0);
        wr(demand_pkg::A_CTRL, 32'h41, 2'h0);
        wait_flag(6 * TK);
        chk("fault delay", 32'(n >= 3 * TK), 32'h1);
        chk("primary failed", primary_failed, 1'b0);
        chk("backup failed", backup_failed, 1'b1);
        chk("backup control", backup_in_control, 1'b0);
        chk("demand", demand_out, 8'h32);
        drv(8'h32, 8'h35, 8'h00);
        repeat (3 * TK) @(posedge aclk);
        chk("fault cleared", track_fault, 1'b0);
        drv(8'h32, 8'h41, 8'h00);
        drv(8'h32, 8'h32, 8'h00);
        repeat (6 * TK) @(posedge aclk);
        chk("brief deviation", track_fault, 1'b0);
        wr(demand_pkg::A_CTRL, 32'h43, 2'h0);
        drv(8'h32, 8'h41, 8'h00);
        wait_flag(6 * TK);
        chk("primary failed", primary_failed, 1'b1);
        chk("backup control", backup_in_control, 1'b1);
        chk("demand", demand_out, 8'h41);
        slow <= 1'b1;
        drv(8'h32, 8'h3A, 8'h00);
        repeat (6 * TK) @(posedge aclk);
        chk("backup held", backup_in_control, 1'b1);
        drv(8'h32, 8'h36, 8'h00);
        for (n = 0; n < 6 * TK && backup_in_control !== 1'b0; n++) @(posedge aclk);
        tmo(n, 6 * TK);
        repeat (2) @(posedge aclk);
        chk("failback demand", demand_out, 8'h32);
        slow <= 1'b0;
        $display("test tracking done");
        wr(demand_pkg::A_CTRL, 32'h0, 2'h0);
        drv(8'h0A, 8'h00, 8'h00);
        // Each pass lasts 120 cycles, a whole number of ticks, so every pass starts in the same tick phase
        for (i = 0; i < 3; i++) begin
            wr(demand_pkg::A_FILT, i == 0 ? 32'h19 : (i == 1 ? 32'h14 : 32'h01), 2'h0);
            wr(demand_pkg::A_CTRL, 32'h4, 2'h0);
            drv(8'h5A, 8'h00, 8'h00);
            repeat (10 * TK) @(posedge aclk);
            dv[i] = demand_out;
            wr(demand_pkg::A_CTRL, 32'h0, 2'h0);
            drv(8'h0A, 8'h00, 8'h00);
        end
        chk("cutoff clamp", {24'h0, dv[0]}, {24'h0, dv[1]});
        chk("filtered lags", 32'(dv[1] < 8'h64), 32'h1);
        chk("cutoff order", {31'h0, dv[1] > dv[2]}, 32'h1);
        $display("test filter done");
        end_of_test();
    end
endmodule : tb_demand_front_end
